// [core/mcpl_top.sv]
// Purpose: pin-level logic of a digital motion controller
// Assumes: host strobes and pins synchronous to i_ref_clk; encoder pre-filtered
// Notes:   filter and profile algorithms are outside; a simple decel stands in
// Behaviour
// R1 - eight-bit host port; low six lines carry address during address phase.
// R2 - address strobe captures low six bus lines into the address latch.
// R3 - chip select with write stores bus data at the latched address.
// R4 - chip select with read copies addressed location into output latch.
// R5 - host asserts output enable; device drives output latch onto bus then.
// R6 - encoder supplies two quadrature channels a quarter period apart.
// R7 - index used only for commutation; either polarity accepted.
// R8 - low limit input sets limit flag, readable in status register.
// R9 - limit flag forces idle before next sample and zero motor command.
// R10 - limit entry to idle leaves the three mode flags unchanged.
// R11 - host should clear all mode flags after a limit event.
// R12 - low stop input sets stop flag; acts only in integral velocity mode.
// R13 - stop decelerates command to zero, held until cleared and new velocity.
// R14 - emergency flag clears only after pin high and then status write.
// R15 - such a status write clears flag; low four bits update configuration.
// R16 - sync acts only in idle mode.
// R17 - sync low in idle clears and holds sample timer at zero.
// R18 - sync high restarts timer counting down from reload value.
// R19 - host ties sync lines together and drives one low pulse.
// R20 - eight-bit offset-binary motor command, top bit on highest line.
// R21 - pulse period of 100 clocks, high time proportional to magnitude.
// R22 - sign output gives polarity of the pulse output.
// R23 - profile output high during profiled move; idle output high in idle.
// R24 - reset clears all logic and enters reset mode; the register memory array is not reset.
// R25 - limit, stop and sync sampled on rising clock edges before use.
`timescale 1ns/100ps
`default_nettype none
module mcpl_top (
  input  wire logic       i_ref_clk,
  input  wire logic       i_rstn,
  input  wire logic       i_ale_n,
  input  wire logic       i_cs_n,
  input  wire logic       i_rd_wr_n,
  input  wire logic       i_oe_n,
  input  wire logic [5:0] i_muxed_addr_data_low,
  input  wire logic [1:0] i_data_only_high_lines,
  output logic      [7:0] o_data,
  output logic            o_data_oe,
  input  wire logic       i_quad_input_a,
  input  wire logic       i_quad_input_b,
  input  wire logic       i_index,
  input  wire logic       i_limit_n,
  input  wire logic       i_stop_n,
  input  wire logic       i_sync_n,
  input  wire logic       i_run_ctrl,
  input  wire logic       i_run_prof,
  input  wire logic       i_int_vel_mode,
  input  wire logic [7:0] i_filter_cmd,
  output logic      [7:0] o_motor_cmd_out,
  output logic            o_pulse,
  output logic            o_sign,
  output logic      [3:0] o_winding_enable_outs,
  output logic            o_prof,
  output logic            o_idle,
  output logic      [2:0] o_mode_flags,
  output logic            o_sample_tick
);
  // reset release through two flops
  logic rst_s1_r;
  logic rst_n;
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_s1_r <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n    <= rst_s1_r;
    end
  end

  function automatic logic [7:0] mcpl_mag(input logic [7:0] cmd);
    mcpl_mag = cmd[7] ? (cmd - mcpl_pkg::MC_ZERO) : (mcpl_pkg::MC_ZERO - cmd);
  endfunction

  // full host bus: low six muxed, high two data only
  wire logic [7:0] bus_in = {i_data_only_high_lines, i_muxed_addr_data_low}; // R1

  // edge detection on chip select; it acts once on its falling edge
  logic cs_d_r;
  wire logic cs_fall  = cs_d_r & ~i_cs_n;
  wire logic wr_stb   = cs_fall & ~i_rd_wr_n;
  wire logic rd_stb   = cs_fall & i_rd_wr_n;

  logic [5:0] addr_r;
  logic [7:0] out_latch_r;
  logic       rd_pend_r;
  logic [3:0] sts_cfg_r;
  logic [7:0] motor_cmd_r;
  logic [7:0] vel_cmd_r;
  logic       vel_new_r;
  logic [7:0] reload_r;
  logic [7:0] timer_r;
  logic       limit_flag_r;
  logic       stop_flag_r;
  logic       limit_pin_hi_r;
  logic       stop_pin_hi_r;
  logic       stop_hold_r;
  logic [6:0] pwm_cnt_r;
  logic       pwm_r;
  logic       sign_r;
  logic [3:0] ring_r;
  logic       index_d_r;
  logic [1:0] quad_d_r;
  mcpl_pkg::mcpl_mode_e       mode_r;
  mcpl_pkg::mcpl_mode_e       mode_nxt;
  mcpl_pkg::mcpl_mode_flags_s flags_r;

  // sampled emergency and sync inputs, one flop each
  logic limit_s_r;
  logic stop_s_r;
  logic sync_s_r;
  logic sync_d_r;
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      limit_s_r <= 1'b1;
      stop_s_r  <= 1'b1;
      sync_s_r  <= 1'b1;
      sync_d_r  <= 1'b1;
    end else begin
      limit_s_r <= i_limit_n; // R25
      stop_s_r  <= i_stop_n; // R25
      sync_s_r  <= i_sync_n; // R25
      sync_d_r  <= sync_s_r;
    end
  end

  // register memory for locations without dedicated logic
  logic [7:0] mem_rdata;
  wire logic is_status = (addr_r == mcpl_pkg::STATUS_ADDR);
  wire logic is_mc     = (addr_r == mcpl_pkg::MOTOR_CMD_ADDR);
  wire logic is_tmr    = (addr_r == mcpl_pkg::SAMPLE_TMR_ADDR);
  wire logic is_vel    = (addr_r == mcpl_pkg::VEL_CMD_ADDR);
  wire logic is_flag   = (addr_r == mcpl_pkg::FLAG_REG_ADDR);
  mcpl_regmem u_mem (
    .i_ref_clk (i_ref_clk),
    .i_we      (wr_stb), // R3
    .i_waddr   (addr_r),
    .i_wdata   (bus_in),
    .i_raddr   (addr_r),
    .o_rdata   (mem_rdata)
  );

  wire logic in_idle  = (mode_r == mcpl_pkg::MCPL_IDLE) | (mode_r == mcpl_pkg::MCPL_RESET);
  wire logic [7:0] status_val = {limit_flag_r, stop_flag_r, in_idle,
                                 (mode_r == mcpl_pkg::MCPL_PROF), sts_cfg_r}; // R8
  wire logic [7:0] read_val = is_status ? status_val :
                              is_mc     ? motor_cmd_r :
                              is_tmr    ? reload_r :
                              is_flag   ? {5'h00, flags_r} : mem_rdata;

  // host bus: address latch, output latch, read pending one cycle for memory
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_d_r      <= 1'b1;
      addr_r      <= 6'h00;
      out_latch_r <= 8'h00;
      rd_pend_r   <= 1'b0;
    end else begin
      cs_d_r  <= i_cs_n;
      if (!i_ale_n) begin
        addr_r <= i_muxed_addr_data_low; // R2
      end
      rd_pend_r <= rd_stb;
      if (rd_pend_r) begin
        out_latch_r <= read_val; // R4
      end
    end
  end

  assign o_data    = out_latch_r;
  assign o_data_oe = ~i_oe_n; // R5

  // emergency flags: set wins; clear needs pin back high, then a status write
  wire logic status_wr = wr_stb & is_status;
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      limit_flag_r   <= 1'b0;
      stop_flag_r    <= 1'b0;
      limit_pin_hi_r <= 1'b0;
      stop_pin_hi_r  <= 1'b0;
      sts_cfg_r      <= 4'h0;
    end else begin
      if (status_wr) begin
        sts_cfg_r <= bus_in[mcpl_pkg::STS_CFG_W-1:0]; // R15
      end
      if (!limit_s_r) begin
        limit_flag_r   <= 1'b1; // R8
        limit_pin_hi_r <= 1'b0;
      end else if (limit_flag_r && limit_pin_hi_r && status_wr) begin
        limit_flag_r   <= 1'b0; // R14
        limit_pin_hi_r <= 1'b0;
      end else if (limit_flag_r) begin
        limit_pin_hi_r <= 1'b1; // R14
      end
      if (!stop_s_r) begin
        stop_flag_r   <= 1'b1; // R12
        stop_pin_hi_r <= 1'b0;
      end else if (stop_flag_r && stop_pin_hi_r && status_wr) begin
        stop_flag_r   <= 1'b0; // R15
        stop_pin_hi_r <= 1'b0;
      end else if (stop_flag_r) begin
        stop_pin_hi_r <= 1'b1;
      end
    end
  end

  // sample timer: sync only honoured in idle
  wire logic sync_hold  = in_idle & ~sync_s_r; // R16
  wire logic sync_rise  = in_idle & sync_s_r & ~sync_d_r;
  wire logic tmr_zero   = (timer_r == 8'h00);
  // no sample on sync release: the held zero is not a count end, the reload starts then
  wire logic sample     = tmr_zero & ~sync_hold & ~sync_rise; // R18
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_r  <= 8'h00;
      reload_r <= mcpl_pkg::SAMPLE_RELOAD_RST;
    end else begin
      if (wr_stb && is_tmr) begin
        reload_r <= bus_in;
      end
      if (sync_hold) begin
        timer_r <= 8'h00; // R17
      end else if (sync_rise || tmr_zero) begin
        timer_r <= reload_r; // R18
      end else begin
        timer_r <= timer_r - 8'h01;
      end
    end
  end
  assign o_sample_tick = sample;

  // mode machine; limit overrides any control mode, mode flags untouched
  always_comb begin
    mode_nxt = mode_r;
    unique case (mode_r)
      mcpl_pkg::MCPL_RESET: mode_nxt = mcpl_pkg::MCPL_IDLE;
      mcpl_pkg::MCPL_IDLE:  if (i_run_prof && !limit_flag_r) mode_nxt = mcpl_pkg::MCPL_PROF;
                            else if (i_run_ctrl && !limit_flag_r) mode_nxt = mcpl_pkg::MCPL_CTRL;
      mcpl_pkg::MCPL_CTRL:  if (!i_run_ctrl) mode_nxt = mcpl_pkg::MCPL_IDLE;
      mcpl_pkg::MCPL_PROF:  if (!i_run_prof) mode_nxt = mcpl_pkg::MCPL_CTRL;
    endcase
    if (limit_flag_r && mode_r != mcpl_pkg::MCPL_RESET) begin
      mode_nxt = mcpl_pkg::MCPL_IDLE; // R9
    end
  end

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_r  <= mcpl_pkg::MCPL_RESET; // R24
      flags_r <= '0;
    end else begin
      mode_r <= mode_nxt;
      // only host writes to the flag location change the mode flags
      if (wr_stb && is_flag) begin
        flags_r <= bus_in[2:0]; // R10
      end
    end
  end
  assign o_mode_flags = flags_r;

  // motor command: zero on limit, decel on stop in integral velocity mode
  wire logic in_ctrl  = (mode_r == mcpl_pkg::MCPL_CTRL) | (mode_r == mcpl_pkg::MCPL_PROF);
  wire logic stop_act = stop_flag_r & i_int_vel_mode & in_ctrl; // R12
  wire logic [7:0] decel_cmd = (motor_cmd_r == mcpl_pkg::MC_ZERO) ? mcpl_pkg::MC_ZERO :
                               motor_cmd_r[7] ? motor_cmd_r - mcpl_pkg::DECEL_STEP :
                                                motor_cmd_r + mcpl_pkg::DECEL_STEP;
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      motor_cmd_r <= mcpl_pkg::MC_ZERO;
      vel_cmd_r   <= mcpl_pkg::MC_ZERO;
      vel_new_r   <= 1'b0;
      stop_hold_r <= 1'b0;
    end else begin
      if (wr_stb && is_vel) begin
        vel_cmd_r <= bus_in;
        vel_new_r <= 1'b1;
      end
      if (stop_act) begin
        stop_hold_r <= 1'b1;
        vel_new_r   <= 1'b0;
      end else if (stop_hold_r && !stop_flag_r && vel_new_r) begin
        stop_hold_r <= 1'b0; // R13
      end
      if (limit_flag_r) begin
        motor_cmd_r <= mcpl_pkg::MC_ZERO; // R9
      end else if (in_ctrl && sample) begin
        if (stop_hold_r || stop_act) begin
          motor_cmd_r <= decel_cmd; // R13
        end else if (i_int_vel_mode) begin
          motor_cmd_r <= vel_cmd_r;
        end else begin
          motor_cmd_r <= i_filter_cmd;
        end
      end else if (in_idle && wr_stb && is_mc) begin
        motor_cmd_r <= bus_in;
      end
    end
  end
  assign o_motor_cmd_out = motor_cmd_r; // R20

  // pwm: period 100 clocks, high for magnitude clocks, saturates at full
  wire logic [7:0] mag = mcpl_mag(motor_cmd_r);
  wire logic       cnt_wrap = (pwm_cnt_r == (mcpl_pkg::PWM_PERIOD - 7'h01));
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwm_cnt_r <= 7'h00;
      pwm_r     <= 1'b0;
      sign_r    <= 1'b0;
    end else begin
      pwm_cnt_r <= cnt_wrap ? 7'h00 : pwm_cnt_r + 7'h01; // R21
      pwm_r     <= ({1'b0, pwm_cnt_r} < mag); // R21
      sign_r    <= ~motor_cmd_r[7]; // R22
    end
  end
  assign o_pulse = pwm_r;
  assign o_sign  = sign_r;

  // commutation ring, reset by index edge of either polarity
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ring_r    <= 4'h1;
      index_d_r <= 1'b0;
      quad_d_r  <= 2'h0;
    end else begin
      index_d_r <= i_index;
      quad_d_r  <= {i_quad_input_a, i_quad_input_b};
      if (index_d_r != i_index) begin
        ring_r <= 4'h1; // R7
      end else if (in_ctrl && (quad_d_r != {i_quad_input_a, i_quad_input_b})) begin
        ring_r <= {ring_r[2:0], ring_r[3]}; // R6
      end
    end
  end
  assign o_winding_enable_outs = in_ctrl ? ring_r : 4'h0;

  assign o_prof = (mode_r == mcpl_pkg::MCPL_PROF); // R23
  assign o_idle = in_idle; // R23
endmodule
`default_nettype wire

// [core/mcpl_pkg.sv]
// Purpose: shared constants and types for the motion controller pin logic
// Assumes: one 100 MHz clock, synchronous pin inputs
// Notes:   register offsets are 6-bit host addresses
package mcpl_pkg;
  localparam int          ADDR_W          = 6;
  localparam int          DATA_W          = 8;
  localparam int          MEM_DEPTH       = 64;
  localparam logic [5:0]  STATUS_ADDR     = 6'h07;
  localparam logic [5:0]  MOTOR_CMD_ADDR  = 6'h08;
  localparam logic [5:0]  PWM_CMD_ADDR    = 6'h09;
  localparam logic [5:0]  SAMPLE_TMR_ADDR = 6'h0f;
  localparam logic [5:0]  VEL_CMD_ADDR    = 6'h0b;
  localparam logic [5:0]  FLAG_REG_ADDR   = 6'h00;
  localparam int          STS_CFG_W       = 4;
  localparam int          STS_PROF_BIT    = 4;
  localparam int          STS_IDLE_BIT    = 5;
  localparam int          STS_STOP_BIT    = 6;
  localparam int          STS_LIMIT_BIT   = 7;
  localparam logic [7:0]  MC_ZERO         = 8'h80;
  localparam logic [6:0]  PWM_PERIOD      = 7'h64;
  localparam logic [7:0]  SAMPLE_RELOAD_RST = 8'h40;
  localparam logic [7:0]  DECEL_STEP      = 8'h01;

  typedef enum logic [3:0] {
    MCPL_RESET = 4'h1,
    MCPL_IDLE  = 4'h2,
    MCPL_CTRL  = 4'h4,
    MCPL_PROF  = 4'h8
  } mcpl_mode_e;

  typedef struct packed {
    logic ctrl_a;
    logic ctrl_b;
    logic ctrl_c;
  } mcpl_mode_flags_s;

  typedef struct packed {
    logic       ale_n;
    logic       cs_n;
    logic       rd_wr_n;
    logic       oe_n;
    logic [7:0] data_in;
  } mcpl_host_s;
endpackage

// [core/mcpl_regmem.sv]
// Purpose: 64 x 8 register memory with registered read data
// Assumes: single write port, single read port, one clock
// Notes:   no reset on the array; contents are undefined until written
`timescale 1ns/100ps
`default_nettype none
module mcpl_regmem (
  input  wire logic       i_ref_clk,
  input  wire logic       i_we,
  input  wire logic [5:0] i_waddr,
  input  wire logic [7:0] i_wdata,
  input  wire logic [5:0] i_raddr,
  output logic      [7:0] o_rdata
);
  logic [7:0] mem_r [0:mcpl_pkg::MEM_DEPTH-1];

  always_ff @(posedge i_ref_clk) begin
    if (i_we) begin
      mem_r[i_waddr] <= i_wdata;
    end
    o_rdata <= mem_r[i_raddr];
  end
endmodule
`default_nettype wire

// [dv/mcpl_checker.sv]
// Purpose: assertions on the pin logic outputs
// Assumes: internal reset ends two edges after i_rstn rises
// Notes:   an age counter masks that synchroniser lag
`timescale 1ns/100ps
`default_nettype none
module mcpl_checker (
  input wire logic       i_ref_clk,
  input wire logic       i_rstn,
  input wire logic       i_oe_n,
  input wire logic       i_cs_n,
  input wire logic       i_limit_n,
  input wire logic       i_stop_n,
  input wire logic       i_sync_n,
  input wire logic       i_int_vel_mode,
  input wire logic       o_data_oe,
  input wire logic [7:0] o_motor_cmd_out,
  input wire logic       o_pulse,
  input wire logic       o_sign,
  input wire logic       o_prof,
  input wire logic       o_idle,
  input wire logic [2:0] o_mode_flags,
  input wire logic       o_sample_tick
);
  logic [2:0] age_r;
  logic [6:0] gap_r;
  logic       same_r;
  logic       pul_r;
  wire        up   = (age_r == 3'h7);
  wire        rise = o_pulse && !pul_r;
  // a command change may start a pulse mid-period, so only clean periods count
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      age_r  <= 3'h0;
      gap_r  <= 7'h00;
      same_r <= 1'b0;
      pul_r  <= 1'b0;
    end else begin
      age_r  <= up ? age_r : age_r + 3'h1;
      gap_r  <= rise ? 7'h01 : (gap_r == 7'h7f ? gap_r : gap_r + 7'h01);
      same_r <= rise ? 1'b1 : (same_r && $stable(o_motor_cmd_out));
      pul_r  <= o_pulse;
    end
  end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);
  sequence lim_held;
    !i_limit_n [*5];
  endsequence
  sequence bus_quiet;
    i_cs_n [*4];
  endsequence
  oe_drive_a:   assert property (o_data_oe == !i_oe_n)
    else $error("data enable does not follow oe");
  limit_idle_a: assert property (lim_held ##0 up |-> o_idle && o_motor_cmd_out == 8'h80)
    else $error("limit did not force idle and zero command");
  limit_flags_a: assert property (bus_quiet ##0 (up && !i_limit_n) |-> $stable(o_mode_flags))
    else $error("mode flags changed under limit");
  pwm_period_a: assert property (up && rise && same_r |-> gap_r == 7'h64)
    else $error("pulse period not 100 clocks");
  sign_a:       assert property ((up && $stable(o_motor_cmd_out)) [*2] |-> o_sign == !o_motor_cmd_out[7])
    else $error("sign does not match command");
  prof_idle_a:  assert property (o_prof |-> !o_idle)
    else $error("profile and idle both high");
  sync_hold_a:  assert property ((up && o_idle && !i_sync_n) [*3] |-> !o_sample_tick)
    else $error("sample tick while sync held low");
  stop_decel_a: assert property ((up && !i_stop_n && i_int_vel_mode && !o_idle) [*2]
    |-> (o_motor_cmd_out - $past(o_motor_cmd_out)) inside {8'h00, 8'h01, 8'hff})
    else $error("stop command not a gentle ramp");
endmodule
bind mcpl_top mcpl_checker chk_u (.i_ref_clk, .i_rstn, .i_oe_n, .i_cs_n, .i_limit_n, .i_stop_n,
  .i_sync_n, .i_int_vel_mode, .o_data_oe, .o_motor_cmd_out, .o_pulse, .o_sign, .o_prof, .o_idle,
  .o_mode_flags, .o_sample_tick);
`default_nettype wire

// [dv/mcpl_host_model.sv]
// Purpose: host processor on the multiplexed byte bus
// Assumes: drives 1 ns after each rising edge
// Notes:   a released bus shows the inverse of its last byte
`timescale 1ns/100ps
`default_nettype none
module mcpl_host_model (
  input  wire logic       i_ref_clk,
  input  wire logic [7:0] i_wire,
  output var  logic [7:0] o_bus,
  output var  logic       o_ale_n,
  output var  logic       o_cs_n,
  output var  logic       o_rd_wr_n,
  output var  logic       o_oe_n
);
  logic [7:0] last_r = 8'h00;
  initial begin
    o_bus = 8'h00;
    o_ale_n = 1'b1;
    o_cs_n = 1'b1;
    o_rd_wr_n = 1'b1;
    o_oe_n = 1'b1;
  end
  task automatic step();
    @(posedge i_ref_clk);
    #1;
  endtask
  task automatic put(input logic [7:0] v);
    o_bus = v;
    last_r = v;
  endtask
  // top lines carry junk in the address phase on purpose
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    step(); o_ale_n = 1'b0; put({2'b11, a});
    step(); o_ale_n = 1'b1; put(d);
    step(); o_rd_wr_n = 1'b0; o_cs_n = 1'b0;
    step(); o_cs_n = 1'b1; o_rd_wr_n = 1'b1; o_bus = ~last_r;
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    step(); o_ale_n = 1'b0; put({2'b11, a});
    step(); o_ale_n = 1'b1; o_bus = ~last_r;
    step(); o_cs_n = 1'b0;
    step(); o_cs_n = 1'b1; o_oe_n = 1'b0;
    step();
    @(posedge i_ref_clk);
    d = i_wire;
    #1 o_oe_n = 1'b1;
  endtask
endmodule
`default_nettype wire

// [dv/tb.sv]
// Purpose: self-checking bench for the motion controller pin logic
// Assumes: host model owns the bus strobes
// Notes:   profile request is raised only briefly in the prof test; no profile generator behind it
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic       clk = 1'b0;
  logic       rstn = 1'b0;
  logic       qa = 1'b0;
  logic       qb = 1'b0;
  logic       lim_n = 1'b1;
  logic       stp_n = 1'b1;
  logic       syn_n = 1'b1;
  logic       run_c = 1'b0;
  logic       run_p = 1'b0;
  logic       ivel = 1'b0;
  logic [7:0] fcmd = 8'h80;
  logic [7:0] rv;
  logic [7:0] k;
  wire  [7:0] hbus, dout, wbus, mc;
  wire        ale_n, cs_n, rw_n, oe_n, doe, pulse, sign, prof, idle, tick;
  wire  [3:0] wind;
  wire  [2:0] flags;
  wire        idx = qa & qb;
  int         bad_count = 0;
  int         num_checks = 0;
  int         cyc = 0;
  logic [5:0] ta [3] = '{6'h10, 6'h3f, 6'h2a};
  logic [7:0] td [3] = '{8'hc3, 8'h3c, 8'h81};
  assign wbus = doe ? dout : hbus;
  mcpl_top dut_u (.i_ref_clk(clk), .i_rstn(rstn), .i_ale_n(ale_n), .i_cs_n(cs_n),
    .i_rd_wr_n(rw_n), .i_oe_n(oe_n), .i_muxed_addr_data_low(wbus[5:0]),
    .i_data_only_high_lines(wbus[7:6]), .o_data(dout), .o_data_oe(doe), .i_quad_input_a(qa),
    .i_quad_input_b(qb), .i_index(idx), .i_limit_n(lim_n), .i_stop_n(stp_n), .i_sync_n(syn_n),
    .i_run_ctrl(run_c), .i_run_prof(run_p), .i_int_vel_mode(ivel), .i_filter_cmd(fcmd),
    .o_motor_cmd_out(mc), .o_pulse(pulse), .o_sign(sign), .o_winding_enable_outs(wind),
    .o_prof(prof), .o_idle(idle), .o_mode_flags(flags), .o_sample_tick(tick));
  mcpl_host_model host_u (.i_ref_clk(clk), .i_wire(wbus), .o_bus(hbus), .o_ale_n(ale_n),
    .o_cs_n(cs_n), .o_rd_wr_n(rw_n), .o_oe_n(oe_n));
  initial forever #5 clk = ~clk;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // counts ticks or pulse-high clocks over a window
  task automatic count(input int n, input bit use_tick, output logic [7:0] c);
    c = 8'h00;
    repeat (n) begin
      @(posedge clk);
      #1;
      c = c + {7'h00, use_tick ? tick : pulse};
    end
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  always begin
    wait_n(4); qa = ~qa;
    wait_n(4); qb = ~qb;
  end
  initial begin
    wait_n(8); rstn = 1'b1; wait_n(4);
    chk(mc, mcpl_pkg::MC_ZERO);
    chk({7'h00, idle}, 8'h01);
    chk({5'h00, flags}, 8'h00);
    chk({4'h0, wind}, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 3; i++) host_u.wr(ta[i], td[i]);
    for (int i = 0; i < 3; i++) begin
      host_u.rd(ta[i], rv);
      chk(rv, td[i]);
    end
    $display("test bus done");
    foreach (td[i]) begin
      rv = td[i][7] ? 8'h90 : 8'h70;
      host_u.wr(mcpl_pkg::MOTOR_CMD_ADDR, rv);
      wait_n(4);
      chk(mc, rv);
      chk({7'h00, sign}, {7'h00, ~td[i][7]});
      count(100, 1'b0, k);
      chk(k, 8'h10);
    end
    $display("test pwm done");
    host_u.wr(mcpl_pkg::SAMPLE_TMR_ADDR, 8'h20);
    syn_n = 1'b0; wait_n(3);
    count(70, 1'b1, k);
    chk(k, 8'h00);
    syn_n = 1'b1;
    count(36, 1'b1, k);
    chk(k, 8'h01);
    $display("test sync done");
    run_p = 1'b1; wait_n(3);
    chk({6'h00, prof, idle}, 8'h02);
    chk({7'h00, $onehot(wind)}, 8'h01);
    run_p = 1'b0; wait_n(3);
    chk({6'h00, prof, idle}, 8'h01);
    $display("test prof done");
    host_u.wr(mcpl_pkg::FLAG_REG_ADDR, 8'h05);
    run_c = 1'b1; wait_n(4);
    chk({7'h00, idle}, 8'h00);
    syn_n = 1'b0;
    count(70, 1'b1, k);
    chk({7'h00, k != 8'h00}, 8'h01);
    syn_n = 1'b1; lim_n = 1'b0; wait_n(6);
    chk({7'h00, idle}, 8'h01);
    chk(mc, mcpl_pkg::MC_ZERO);
    chk({5'h00, flags}, 8'h05);
    host_u.wr(mcpl_pkg::STATUS_ADDR, 8'h03);
    host_u.rd(mcpl_pkg::STATUS_ADDR, rv);
    chk(rv & 8'hcf, 8'h83);
    lim_n = 1'b1; wait_n(3);
    host_u.rd(mcpl_pkg::STATUS_ADDR, rv);
    chk(rv & 8'h80, 8'h80);
    host_u.wr(mcpl_pkg::STATUS_ADDR, 8'h0a);
    host_u.rd(mcpl_pkg::STATUS_ADDR, rv);
    chk(rv & 8'hcf, 8'h0a);
    host_u.wr(mcpl_pkg::FLAG_REG_ADDR, 8'h00);
    $display("test limit done");
    ivel = 1'b1; fcmd = 8'h90;
    host_u.wr(mcpl_pkg::VEL_CMD_ADDR, 8'h70);
    wait_n(50); stp_n = 1'b0; wait_n(1500);
    chk(mc, mcpl_pkg::MC_ZERO);
    host_u.rd(mcpl_pkg::STATUS_ADDR, rv);
    chk(rv & 8'h40, 8'h40);
    $display("test stop done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
